//--- core/uarx_pkg.sv
// What this block does
// [R1] complete flag set while buffer holds data
// [R2] disable empties buffer, drops frame, clears flag
// [R3] irq while flag and both enables set
// [R4] handler reads data to clear flag
// [R5] error bits stored with each character
// [R6] software reads status before data
// [R7] status writes never change error bits
// [R8] error bits raise no interrupt
// [R9] frame error equals inverted first stop
// [R10] only first stop bit sampled
// [R11] overrun: buffer full, shift full, start
// [R12] overrun cleared on successful transfer
// [R13] parity check only when enabled, typed
// [R14] parity error only if enabled and failed
// [R15] parity disabled reads parity error zero
// [R16] disable immediate, releases pin, loses frame
// [R17] software flushes by reading until empty
// [R18] oversample sixteen, or eight double speed
// [R19] start votes samples 8-10 or 4-6
// [R20] high majority rejects start as noise
// [R21] sixteen or eight states per bit
// [R22] each bit majority of centre samples
// [R23] new start accepted after stop votes
// [R24] first stop moves frame to buffer
// [R25] short characters read upper bits zero
// [R26] ninth bit buffered with each character
// [R27] empty data read changes nothing
package uarx_pkg;
    localparam int unsigned data_width = 9;
    localparam int unsigned fifo_depth = 2;
    localparam logic [4:0] samples_normal = 5'h10;
    localparam logic [4:0] samples_double = 5'h08;
    localparam logic [4:0] vote_first_normal = 5'h08;
    localparam logic [4:0] vote_first_double = 5'h04;
    localparam logic [2:0] size_nine = 3'h7;
    localparam logic [3:0] bits_base = 4'h5;
    localparam logic [3:0] bits_nine = 4'h9;
    localparam logic [1:0] fifo_full_count = 2'h2;
    typedef enum logic [2:0] {
        uarx_idle, uarx_start, uarx_data, uarx_parity, uarx_stop, uarx_held
    } uarx_state_type;
endpackage

//--- core/uarx_receiver.sv
`timescale 1ns/1ns
module uarx_receiver (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial line
    input wire logic serial_input_pin,
    output logic pin_override,
    // oversample tick from the baud generator
    input wire logic sample_tick,
    // configuration
    input wire logic receiver_enable_bit,
    input wire logic rx_complete_irq_enable,
    input wire logic global_irq_enable,
    input wire logic double_speed_select,
    input wire logic parity_enable_bit,
    input wire logic parity_type_bit,
    input wire logic stop_bit_count_select,
    input wire logic [2:0] character_size_field,
    // data read strobe
    input wire logic data_read,
    // status
    output logic rx_complete_flag,
    output logic frame_error_flag,
    output logic overrun_flag,
    output logic parity_error_flag,
    output logic received_ninth_bit,
    output logic [7:0] receive_data_register,
    output logic rx_complete_irq
);
    // ----------------------------------------
    // input synchroniser
    // ----------------------------------------
    logic [2:0] sync_reg;
    logic line_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_reg <= 3'h7;
            line_reg <= 1'b1;
        end else begin
            sync_reg <= {sync_reg[1:0], serial_input_pin};
            if (sync_reg[2] == sync_reg[1]) begin
                line_reg <= sync_reg[2];
            end
        end
    end

    // ----------------------------------------
    // frame format
    // ----------------------------------------
    logic [4:0] spb;
    logic [4:0] vfirst;
    logic [3:0] nbits;
    assign spb = double_speed_select ? uarx_pkg::samples_double : uarx_pkg::samples_normal; // [R18] [R21]
    assign vfirst = double_speed_select ? uarx_pkg::vote_first_double
                                        : uarx_pkg::vote_first_normal; // [R19]
    assign nbits = (character_size_field == uarx_pkg::size_nine) ? uarx_pkg::bits_nine
                 : uarx_pkg::bits_base + {2'h0, character_size_field[1:0]}; // [R25]

    // ----------------------------------------
    // receive state machine
    // ----------------------------------------
    uarx_pkg::uarx_state_type state_reg;
    logic [4:0] sample_reg;
    logic [2:0] vote_reg;
    logic [3:0] bit_reg;
    logic [8:0] shift_reg;
    logic par_reg;
    logic shift_pe_reg;
    logic shift_fe_reg;
    logic vote;
    logic last_sample;
    logic in_vote;
    logic [1:0] count_reg;
    logic push;
    logic pop;
    logic start_seen;
    assign vote = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & vote_reg[2])
                | (vote_reg[1] & vote_reg[2]); // [R22]
    assign in_vote = (sample_reg >= vfirst) && (sample_reg <= vfirst + 5'h2);
    assign last_sample = sample_reg == vfirst + 5'h2;
    assign start_seen = sample_tick && !line_reg
                        && (state_reg == uarx_pkg::uarx_idle || state_reg == uarx_pkg::uarx_held);
    assign pop = data_read && count_reg != 2'h0; // [R27]
    assign push = (state_reg == uarx_pkg::uarx_held) && count_reg != uarx_pkg::fifo_full_count
                  || (state_reg == uarx_pkg::uarx_held) && pop;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= uarx_pkg::uarx_idle;
            sample_reg <= 5'h0;
            vote_reg <= 3'h0;
            bit_reg <= 4'h0;
            shift_reg <= 9'h0;
            par_reg <= 1'b0;
            shift_pe_reg <= 1'b0;
            shift_fe_reg <= 1'b0;
        end else if (!receiver_enable_bit) begin
            state_reg <= uarx_pkg::uarx_idle; // [R2] [R16]
            sample_reg <= 5'h0;
        end else if (push) begin
            state_reg <= uarx_pkg::uarx_idle;
        end else if (sample_tick) begin
            if (in_vote) begin
                vote_reg <= {vote_reg[1:0], line_reg};
            end
            case (state_reg)
                uarx_pkg::uarx_idle, uarx_pkg::uarx_held: begin
                    if (!line_reg) begin
                        state_reg <= uarx_pkg::uarx_start; // [R23]
                        sample_reg <= 5'h2;
                        bit_reg <= 4'h0;
                        shift_reg <= 9'h0;
                        par_reg <= parity_type_bit; // [R13]
                    end
                end
                uarx_pkg::uarx_start: begin
                    sample_reg <= sample_reg + 5'h1;
                    if (sample_reg == vfirst + 5'h3) begin
                        if (vote) begin
                            state_reg <= uarx_pkg::uarx_idle; // [R20]
                        end
                    end
                    if (sample_reg == spb) begin
                        sample_reg <= 5'h1;
                        state_reg <= uarx_pkg::uarx_data; // [R19]
                    end
                end
                uarx_pkg::uarx_data, uarx_pkg::uarx_parity: begin
                    sample_reg <= (sample_reg == spb) ? 5'h1 : sample_reg + 5'h1; // [R21]
                    if (sample_reg == spb) begin
                        if (state_reg == uarx_pkg::uarx_parity) begin
                            shift_pe_reg <= parity_enable_bit && (par_reg != vote); // [R14] [R15]
                            state_reg <= uarx_pkg::uarx_stop;
                        end else begin
                            shift_reg[bit_reg] <= vote;
                            par_reg <= par_reg ^ vote;
                            bit_reg <= bit_reg + 4'h1;
                            if (bit_reg + 4'h1 == nbits) begin
                                state_reg <= parity_enable_bit ? uarx_pkg::uarx_parity
                                                               : uarx_pkg::uarx_stop;
                                shift_pe_reg <= 1'b0; // [R15]
                            end
                        end
                    end
                end
                uarx_pkg::uarx_stop: begin
                    sample_reg <= sample_reg + 5'h1;
                    if (sample_reg == vfirst + 5'h3) begin
                        shift_fe_reg <= !vote; // [R9] [R10]
                        state_reg <= uarx_pkg::uarx_held; // [R24]
                        sample_reg <= 5'h0;
                    end
                end
                default: state_reg <= uarx_pkg::uarx_idle;
            endcase
        end
    end

    // ----------------------------------------
    // two-entry receive buffer
    // ----------------------------------------
    logic [11:0] fifo_mem [uarx_pkg::fifo_depth];
    logic rd_ptr_reg;
    logic ovr_pend_reg;
    logic [11:0] head;
    assign head = fifo_mem[rd_ptr_reg];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovr_pend_reg <= 1'b0;
        end else if (!receiver_enable_bit) begin
            ovr_pend_reg <= 1'b0;
        end else if (push) begin
            ovr_pend_reg <= 1'b0; // [R12]
        end else if (start_seen && state_reg == uarx_pkg::uarx_held) begin
            ovr_pend_reg <= 1'b1; // [R11]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= 2'h0;
            rd_ptr_reg <= 1'b0;
            fifo_mem[0] <= 12'h0;
            fifo_mem[1] <= 12'h0;
        end else if (!receiver_enable_bit) begin
            count_reg <= 2'h0; // [R2]
            rd_ptr_reg <= 1'b0;
        end else begin
            if (push) begin
                fifo_mem[rd_ptr_reg ^ count_reg[0]]
                    <= {shift_fe_reg, ovr_pend_reg, shift_pe_reg, shift_reg}; // [R5] [R26]
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_complete_flag <= 1'b0;
            rx_complete_irq <= 1'b0;
            frame_error_flag <= 1'b0;
            overrun_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            received_ninth_bit <= 1'b0;
            receive_data_register <= 8'h0;
            pin_override <= 1'b0;
        end else begin
            pin_override <= receiver_enable_bit; // [R16]
            rx_complete_flag <= count_reg != 2'h0 && receiver_enable_bit; // [R1]
            rx_complete_irq <= count_reg != 2'h0 && receiver_enable_bit
                               && rx_complete_irq_enable && global_irq_enable; // [R3] [R8]
            frame_error_flag <= head[11]; // [R5] [R7]
            overrun_flag <= head[10];
            parity_error_flag <= head[9] && parity_enable_bit; // [R15]
            received_ninth_bit <= head[8];
            receive_data_register <= head[7:0];
        end
    end
endmodule

//--- test/uarx_receiver_assertions.sv
`timescale 1ns/1ns
module uarx_receiver_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // controls
    input wire logic receiver_enable_bit,
    input wire logic rx_complete_irq_enable,
    input wire logic global_irq_enable,
    input wire logic parity_enable_bit,
    input wire logic [2:0] character_size_field,
    input wire logic data_read,
    // status
    input wire logic pin_override,
    input wire logic rx_complete_flag,
    input wire logic frame_error_flag,
    input wire logic overrun_flag,
    input wire logic parity_error_flag,
    input wire logic [7:0] receive_data_register,
    input wire logic rx_complete_irq
);
    // ----
    // checks
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic cause = rx_complete_flag && rx_complete_irq_enable && global_irq_enable;
    wire logic errs = frame_error_flag || overrun_flag || parity_error_flag;
    property p_irq_on; cause [*3] |-> rx_complete_irq; endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");
    property p_irq_off; !rx_complete_flag && $past(!rx_complete_flag) |-> !rx_complete_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq without data");
    property p_err_irq; errs && !rx_complete_irq_enable && $past(!rx_complete_irq_enable)
        |-> !rx_complete_irq; endproperty
    a_err_irq: assert property (p_err_irq) else $error("irq from error bit");
    property p_flush; $fell(receiver_enable_bit) |-> ##[1:2] !rx_complete_flag; endproperty
    a_flush: assert property (p_flush) else $error("disable kept data");
    property p_pin; $changed(receiver_enable_bit) |=> pin_override == $past(receiver_enable_bit);
    endproperty
    a_pin: assert property (p_pin) else $error("pin override late");
    property p_par_off; !parity_enable_bit && $past(!parity_enable_bit) |-> !parity_error_flag;
    endproperty
    a_par_off: assert property (p_par_off) else $error("parity error while off");
    property p_short; rx_complete_flag && character_size_field == 3'h0
        |-> receive_data_register[7:5] == 3'h0; endproperty
    a_short: assert property (p_short) else $error("upper bits set");
    property p_fall; $fell(rx_complete_flag) |-> $past(data_read) || $past(data_read, 2)
        || $past(data_read, 3) || !$past(receiver_enable_bit) || !$past(receiver_enable_bit, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("flag fell unread");
    c_irq: cover property (rx_complete_irq);
    c_ovr: cover property (overrun_flag);
    c_fe: cover property (frame_error_flag);
endmodule
bind uarx_receiver uarx_receiver_assertions uarx_receiver_assertions_i (.clk, .resetn,
    .receiver_enable_bit, .rx_complete_irq_enable, .global_irq_enable, .parity_enable_bit,
    .character_size_field, .data_read, .pin_override, .rx_complete_flag, .frame_error_flag,
    .overrun_flag, .parity_error_flag, .receive_data_register, .rx_complete_irq);

//--- test/uarx_line_model.sv
`timescale 1ns/1ns
module uarx_line_model (
    // clock and serial line
    input wire logic clk,
    output logic line
);
    // ----
    // remote transmitter, lsb first, idle high
    // ----
    initial line = 1'b1;
    task automatic frame(input logic [11:0] v, input int n, input int bc);
        for (int i = 0; i < n; i++) begin
            line = v[i];
            repeat (bc) @(posedge clk);
            #1;
        end
        line = 1'b1;
    endtask
endmodule

//--- test/uarx_receiver_tb.sv
`timescale 1ns/1ns
module uarx_receiver_tb;
    // ----
    // bench
    // ----
    logic clk = 1'b0, resetn = 1'b0, sample_tick = 1'b0, data_read = 1'b0;
    logic receiver_enable_bit = 1'b0, rx_complete_irq_enable = 1'b1, global_irq_enable = 1'b1;
    logic double_speed_select = 1'b0, parity_enable_bit = 1'b0, parity_type_bit = 1'b0;
    logic stop_bit_count_select = 1'b0;
    logic [2:0] character_size_field = 3'h3;
    logic serial_input_pin, pin_override, rx_complete_flag, frame_error_flag, overrun_flag;
    logic parity_error_flag, received_ninth_bit, rx_complete_irq;
    logic [7:0] receive_data_register;
    int num_errors = 0, checks = 0, cycles = 0;
    uarx_line_model uarx_line_model_i (.clk, .line(serial_input_pin));
    uarx_receiver uarx_receiver_i (.clk, .resetn, .serial_input_pin, .pin_override, .sample_tick,
        .receiver_enable_bit, .rx_complete_irq_enable, .global_irq_enable, .double_speed_select,
        .parity_enable_bit, .parity_type_bit, .stop_bit_count_select, .character_size_field,
        .data_read, .rx_complete_flag, .frame_error_flag, .overrun_flag, .parity_error_flag,
        .received_ninth_bit, .receive_data_register, .rx_complete_irq);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        #1 sample_tick = ~sample_tick;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // expected: frame, overrun, parity error, flag, ninth bit, data
    task automatic head(input logic [12:0] e);
        chk({3'h0, frame_error_flag, overrun_flag, parity_error_flag, rx_complete_flag,
            received_ninth_bit, receive_data_register}, {3'h0, e});
    endtask
    task automatic flag(input logic e);
        chk({15'h0, rx_complete_flag}, {15'h0, e});
    endtask
    task automatic rd;
        @(posedge clk);
        #1 data_read = 1'b1;
        @(posedge clk);
        #1 data_read = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic send(input logic [11:0] v, input int n);
        uarx_line_model_i.frame(v, n, double_speed_select ? 16 : 32);
        repeat (4) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 resetn = 1'b1;
        receiver_enable_bit = 1'b1;
        send({1'b1, 8'ha5, 1'b0}, 10);
        head({4'h1, 1'b0, 8'ha5});
        chk({15'h0, rx_complete_irq}, 16'h0001);
        rd();
        flag(1'b0);
        rd();
        flag(1'b0);
        $display("basic done");
        rx_complete_irq_enable = 1'b0;
        parity_enable_bit = 1'b1;
        send({1'b1, 1'b1, 8'h03, 1'b0}, 11);
        parity_type_bit = 1'b1;
        send({1'b0, 1'b1, 8'h03, 1'b0}, 11);
        head({4'h3, 1'b0, 8'h03});
        rd();
        head({4'h9, 1'b0, 8'h03});
        rd();
        parity_enable_bit = 1'b0;
        rx_complete_irq_enable = 1'b1;
        $display("errors done");
        for (int i = 1; i < 5; i++) send({1'b1, 8'(i * 17), 1'b0}, 10);
        head({4'h1, 1'b0, 8'h11});
        rd();
        head({4'h1, 1'b0, 8'h22});
        rd();
        head({4'h5, 1'b0, 8'h44});
        rd();
        send({1'b1, 8'h55, 1'b0}, 10);
        head({4'h1, 1'b0, 8'h55});
        rd();
        flag(1'b0);
        $display("overrun done");
        uarx_line_model_i.frame(12'h000, 1, 6);
        repeat (64) @(posedge clk);
        flag(1'b0);
        send({1'b1, 8'h66, 1'b0}, 10);
        head({4'h1, 1'b0, 8'h66});
        rd();
        $display("noise done");
        character_size_field = 3'h7;
        double_speed_select = 1'b1;
        stop_bit_count_select = 1'b1;
        send({1'b1, 9'h1c3, 1'b0}, 11);
        head({4'h1, 1'b1, 8'hc3});
        rd();
        character_size_field = 3'h0;
        double_speed_select = 1'b0;
        send({1'b1, 5'h1f, 1'b0}, 7);
        head({4'h1, 1'b0, 8'h1f});
        rd();
        character_size_field = 3'h3;
        $display("formats done");
        send({1'b1, 8'haa, 1'b0}, 10);
        fork
            send({1'b1, 8'hbb, 1'b0}, 10);
            begin
                repeat (150) @(posedge clk);
                #1 receiver_enable_bit = 1'b0;
            end
        join
        flag(1'b0);
        chk({15'h0, pin_override}, 16'h0000);
        receiver_enable_bit = 1'b1;
        repeat (40) @(posedge clk);
        flag(1'b0);
        $display("disable done");
        close_out();
    end
endmodule
